// ### rtl/arcrc_consts.vh
// register map, field positions, reset values and timing counts
`ifndef ARCRC_CONSTS_VH
`define ARCRC_CONSTS_VH

// register indices, byte address is four times the index
`define ARCRC_IDX_DATA_RATE 6'h04
`define ARCRC_IDX_REF_CTRL 6'h05
`define ARCRC_IDX_STATUS 6'h06
`define ARCRC_IDX_CTRL 6'h07

// data_rate_config fields
`define ARCRC_DR_RATE_LSB 0
`define ARCRC_DR_FILT_BIT 4
`define ARCRC_DR_CLK_BIT 6
`define ARCRC_DR_RESET 8'h14

// reference_control fields
`define ARCRC_RC_PWR_LSB 0
`define ARCRC_RC_SEL_LSB 2
`define ARCRC_RC_NBUF_BIT 4
`define ARCRC_RC_PBUF_BIT 5
`define ARCRC_RC_RESET 8'h30

// control register fields
`define ARCRC_CTRL_PDN_BIT 0
`define ARCRC_CTRL_RUN_BIT 1
`define ARCRC_CTRL_RST_BIT 2
`define ARCRC_CTRL_RESET 8'h00

// field codes
`define ARCRC_PWR_AUTO 2'h1
`define ARCRC_PWR_ALWAYS 2'h2
`define ARCRC_SEL_EXT0 2'h0
`define ARCRC_SEL_EXT1 2'h1
`define ARCRC_SEL_INT 2'h2

// modulator clock divider: last count of a divide by 16
`define ARCRC_MOD_DIV_LAST 4'hF

// oversampling ratios in modulator clocks, codes 0 to 13
`define ARCRC_OSR_0 17'h19000
`define ARCRC_OSR_1 17'h0C800
`define ARCRC_OSR_2 17'h06400
`define ARCRC_OSR_3 17'h03C00
`define ARCRC_OSR_4 17'h03200
`define ARCRC_OSR_5 17'h01400
`define ARCRC_OSR_6 17'h010A8
`define ARCRC_OSR_7 17'h00A00
`define ARCRC_OSR_8 17'h00500
`define ARCRC_OSR_9 17'h00280
`define ARCRC_OSR_10 17'h00140
`define ARCRC_OSR_11 17'h00100
`define ARCRC_OSR_12 17'h00080
`define ARCRC_OSR_13 17'h00040

`endif

// ### rtl/arcrc_mod_clk.v
// system clock selection and modulator clock enable divider
`timescale 1ns/1ps
`default_nettype none
`include "arcrc_consts.vh"

module arcrc_mod_clk (
  input wire clk_i,
  input wire rst_i,
  input wire int_osc_tick_i,
  input wire ext_clk_i,
  input wire ext_sel_i,
  output reg mod_tick_o
);

  reg ext_s1_q; // first sync stage, read only by second
  reg ext_s2_q; // second sync stage
  reg ext_s3_q; // delayed copy for edge detect
  reg sel_q; // last source, to spot a switch
  reg [3:0] div_q; // divide by 16 counter
  wire sys_tick; // one tick per selected system clock

  // external clock rising edge, or internal tick
  assign sys_tick = ext_sel_i ? (ext_s2_q & ~ext_s3_q) : int_osc_tick_i;

  // synchroniser and divider
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ext_s1_q <= 1'b0;
      ext_s2_q <= 1'b0;
      ext_s3_q <= 1'b0;
      sel_q <= 1'b0;
      div_q <= 4'h0;
      mod_tick_o <= 1'b0;
    end
    else
    begin
      ext_s1_q <= ext_clk_i;
      ext_s2_q <= ext_s1_q;
      ext_s3_q <= ext_s2_q;
      sel_q <= ext_sel_i;
      mod_tick_o <= 1'b0;
      // restart the divide on a source switch, no runt period
      if (sel_q != ext_sel_i)
      begin
        div_q <= 4'h0;
      end
      else if (sys_tick)
      begin
        div_q <= div_q + 4'h1;
        mod_tick_o <= (div_q == `ARCRC_MOD_DIV_LAST);
      end
    end
  end

endmodule // arcrc_mod_clk
`default_nettype wire

// ### rtl/arcrc_conv.v
// conversion timer: counts modulator clocks per result
`timescale 1ns/1ps
`default_nettype none
`include "arcrc_consts.vh"

module arcrc_conv (
  input wire clk_i,
  input wire rst_i,
  input wire mod_tick_i,
  input wire run_i,
  input wire restart_i,
  input wire [3:0] rate_code_i,
  output reg done_o
);

  reg [16:0] cnt_q; // modulator clocks into current result
  wire [16:0] osr; // ratio for the current code

  // ratio per rate code, zero for undefined codes
  function [16:0] arcrc_osr;
    input [3:0] code;
    begin
      case (code)
        4'h0: arcrc_osr = `ARCRC_OSR_0;
        4'h1: arcrc_osr = `ARCRC_OSR_1;
        4'h2: arcrc_osr = `ARCRC_OSR_2;
        4'h3: arcrc_osr = `ARCRC_OSR_3;
        4'h4: arcrc_osr = `ARCRC_OSR_4;
        4'h5: arcrc_osr = `ARCRC_OSR_5;
        4'h6: arcrc_osr = `ARCRC_OSR_6;
        4'h7: arcrc_osr = `ARCRC_OSR_7;
        4'h8: arcrc_osr = `ARCRC_OSR_8;
        4'h9: arcrc_osr = `ARCRC_OSR_9;
        4'hA: arcrc_osr = `ARCRC_OSR_10;
        4'hB: arcrc_osr = `ARCRC_OSR_11;
        4'hC: arcrc_osr = `ARCRC_OSR_12;
        4'hD: arcrc_osr = `ARCRC_OSR_13;
        default: arcrc_osr = 17'h00000;
      endcase
    end
  endfunction

  assign osr = arcrc_osr(rate_code_i);

  // filter type never enters the count
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cnt_q <= 17'h00000;
      done_o <= 1'b0;
    end
    else
    begin
      done_o <= 1'b0;
      // stopped, retuned or undefined code: no result
      if (restart_i || !run_i || (osr == 17'h00000))
      begin
        cnt_q <= 17'h00000;
      end
      else if (mod_tick_i)
      begin
        if (cnt_q == osr - 17'h00001)
        begin
          cnt_q <= 17'h00000;
          done_o <= 1'b1;
        end
        else
        begin
          cnt_q <= cnt_q + 17'h00001;
        end
      end
    end
  end

endmodule // arcrc_conv
`default_nettype wire

// ### rtl/arcrc_top.v
// reference, clock and data-rate control with a wishbone register slave
//
// Register access over Wishbone was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "arcrc_consts.vh"

module arcrc_top (
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  input wire int_osc_tick_i,
  input wire ext_clk_i,
  output reg int_ref_en_o,
  output reg ref_sel_int_o,
  output reg ref_sel_ext0_o,
  output reg ref_sel_ext1_o,
  output reg pos_buf_en_o,
  output reg neg_buf_en_o,
  output reg sys_clk_ext_o,
  output wire mod_tick_o,
  output reg lowlat_filter_o,
  output reg sinc3_filter_o,
  output reg notch_50_o,
  output reg notch_60_o,
  output wire data_ready_o,
  output reg power_down_o
);

  // register storage
  // only the low byte of each word is kept, upper lanes read zero
  reg [7:0] data_rate_config_q; // rate code, filter, clock select
  reg [7:0] reference_control_q; // power, source, buffer bits
  reg [7:0] ctrl_q; // power-down and run bits
  reg result_tgl_q; // flips on every finished result

  // bus decode
  // the map holds four byte-wide registers, each in the low byte
  // of an aligned word; word index is the byte address over four
  //   index 4: data_rate_config, index 5: reference_control
  //   index 6: status (read only), index 7: control
  // everything else acks and reads zero so a stray access
  // from software never stalls the bus
  wire req; // a new request this cycle
  wire wr_lo; // write hitting the low byte lane
  wire [5:0] idx; // word index from the byte address
  wire hit_dr; // data_rate_config selected
  wire hit_rc; // reference_control selected
  wire hit_st; // status selected
  wire hit_ct; // control selected
  wire rst_cmd; // reset command written by software
  wire cfg_rst; // pin reset or reset command
  wire restart; // data_rate_config write or reset restarts conversion
  reg [7:0] rd_byte; // read mux result

  // field views
  // named slices of the stored registers, combinational
  wire [3:0] rate_code; // oversampling choice
  wire filter_sinc3; // 1 selects sinc3
  wire clk_ext_sel; // 1 selects external clock
  wire [1:0] internal_ref_power_field; // reference power code
  wire [1:0] ref_source_select; // reference mux code
  wire pos_ref_buffer_off; // active-low enable of positive buffer
  wire neg_ref_buffer_off; // active-low enable of negative buffer
  wire pdn; // device in power-down
  wire run; // conversions running
  wire ref_on; // internal reference powered
  wire rate_bad; // undefined rate code stored

  // notch on a line frequency for a rate code
  // only meaningful for the low-latency filter
  // rates are grouped by result, not listed in code order
  function notch_hit;
    input [3:0] code;
    input sixty;
    begin
      case (code)
        // slowest rates and 20 SPS reject both line frequencies
        4'h0: notch_hit = 1'b1;
        4'h1: notch_hit = 1'b1;
        4'h2: notch_hit = 1'b1;
        4'h4: notch_hit = 1'b1;
        // 16.6 and 50 SPS notch only the 50 Hz line
        4'h3: notch_hit = ~sixty;
        4'h5: notch_hit = ~sixty;
        // 60 SPS notches only the 60 Hz line
        4'h6: notch_hit = sixty;
        // faster rates leave line noise to the sinc3 path or the user
        default: notch_hit = 1'b0;
      endcase
    end
  endfunction

  // classic single cycle: one request per ack
  // masking with the ack keeps a held request from being
  // taken twice; the master drops stb in the ack cycle
  assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr_lo = req & wb_we_i & wb_sel_i[0];
  assign idx = wb_adr_i[7:2];

  // address decode
  // only the word index is compared, low address bits ignored
  assign hit_dr = (idx == `ARCRC_IDX_DATA_RATE);
  assign hit_rc = (idx == `ARCRC_IDX_REF_CTRL);
  assign hit_st = (idx == `ARCRC_IDX_STATUS);
  assign hit_ct = (idx == `ARCRC_IDX_CTRL);

  // reset command bit acts in the write cycle itself
  // it clears configuration, result toggle and conversion count; the bus answer and the
  // output flops keep running so the write is still acked
  assign rst_cmd = wr_lo & hit_ct & wb_dat_i[`ARCRC_CTRL_RST_BIT];
  assign cfg_rst = rst_i | rst_cmd;

  // new rate or filter restarts so the first result is settled
  assign restart = cfg_rst | (wr_lo & hit_dr);

  // field extraction
  // positions come from the constants header
  assign rate_code = data_rate_config_q[`ARCRC_DR_RATE_LSB+3:`ARCRC_DR_RATE_LSB];
  assign filter_sinc3 = data_rate_config_q[`ARCRC_DR_FILT_BIT];
  assign clk_ext_sel = data_rate_config_q[`ARCRC_DR_CLK_BIT];
  assign internal_ref_power_field = reference_control_q[`ARCRC_RC_PWR_LSB+1:`ARCRC_RC_PWR_LSB];
  assign ref_source_select = reference_control_q[`ARCRC_RC_SEL_LSB+1:`ARCRC_RC_SEL_LSB];
  assign pos_ref_buffer_off = reference_control_q[`ARCRC_RC_PBUF_BIT];
  assign neg_ref_buffer_off = reference_control_q[`ARCRC_RC_NBUF_BIT];
  assign pdn = ctrl_q[`ARCRC_CTRL_PDN_BIT];
  assign run = ctrl_q[`ARCRC_CTRL_RUN_BIT];
  // codes 1110 and 1111 give no results, flagged in status
  // the conversion timer sees a zero ratio for them and idles
  assign rate_bad = (rate_code > 4'hD);

  // always-on code ignores power-down, auto code obeys it
  // any other code leaves the reference off
  // code 11 is treated as off, the safe choice for an
  // unlisted setting; the reference output then stays low
  assign ref_on = (internal_ref_power_field == `ARCRC_PWR_ALWAYS) |
                  ((internal_ref_power_field == `ARCRC_PWR_AUTO) & ~pdn);

  // configuration registers
  // reset command clears them like the pin, so a stale
  // external clock choice cannot survive a software reset
  always @(posedge clk_i)
  begin
    if (cfg_rst)
    begin
      // clock select back to internal oscillator
      data_rate_config_q <= `ARCRC_DR_RESET;
      // reference off, external pair zero selected
      reference_control_q <= `ARCRC_RC_RESET;
      // power-down and run cleared, conversions stop
      ctrl_q <= `ARCRC_CTRL_RESET;
    end
    else if (wr_lo)
    begin
      // byte writes on lane zero only, upper lanes are not stored
      if (hit_dr)
      begin
        // undefined rate codes are stored as written and only
        // reported in status, they never produce a result
        data_rate_config_q <= wb_dat_i[7:0];
      end
      else if (hit_rc)
      begin
        reference_control_q <= wb_dat_i[7:0];
      end
      else if (hit_ct)
      begin
        // reset bit is a command and never stored
        ctrl_q <= wb_dat_i[7:0] & ~(8'h01 << `ARCRC_CTRL_RST_BIT);
      end
    end
  end

  // read mux, status is live block state
  // status bits, low to high:
  //   0 internal reference powered
  //   1 external system clock selected
  //   2 low-latency filter selected
  //   3 50 Hz notch active
  //   4 60 Hz notch active
  //   5 conversions enabled
  //   6 toggles once per finished result
  //   7 undefined rate code stored
  // status bits 0 to 4 lag a register write by one cycle, those outputs are flops
  always @*
  begin
    rd_byte = 8'h00;
    if (hit_dr)
    begin
      rd_byte = data_rate_config_q;
    end
    else if (hit_rc)
    begin
      rd_byte = reference_control_q;
    end
    else if (hit_st)
    begin
      rd_byte = {rate_bad, result_tgl_q, run, notch_60_o,
                 notch_50_o, lowlat_filter_o, sys_clk_ext_o, int_ref_en_o};
    end
    else if (hit_ct)
    begin
      rd_byte = ctrl_q;
    end
  end

  // bus answer one cycle after the request
  // unmapped addresses are acked and read zero
  // read data is captured with the ack so it stands while
  // the master samples it, and holds until the next request, read or write
  // a fixed one-cycle answer keeps the master simple
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end
    else
    begin
      wb_ack_o <= req;
      if (req)
      begin
        wb_dat_o <= {24'h000000, rd_byte};
      end
    end
  end

  // result toggle seen by software through status
  // a toggle rather than a sticky flag needs no clear path,
  // software compares it against its last read value
  always @(posedge clk_i)
  begin
    if (cfg_rst)
    begin
      result_tgl_q <= 1'b0;
    end
    else if (data_ready_o)
    begin
      result_tgl_q <= ~result_tgl_q;
    end
  end

  // registered control outputs toward the analog side
  // every analog control is a flop so the switches see no
  // decode glitches while a register is rewritten
  // reset values match what the register reset values decode to
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      int_ref_en_o <= 1'b0;
      ref_sel_int_o <= 1'b0;
      // external pair zero routed from reset
      ref_sel_ext0_o <= 1'b1;
      ref_sel_ext1_o <= 1'b0;
      // register reset value has both buffers off
      pos_buf_en_o <= 1'b0;
      neg_buf_en_o <= 1'b0;
      sys_clk_ext_o <= 1'b0;
      lowlat_filter_o <= 1'b0;
      // sinc3 chosen at reset, as the register says
      sinc3_filter_o <= 1'b1;
      notch_50_o <= 1'b0;
      notch_60_o <= 1'b0;
      power_down_o <= 1'b0;
    end
    else
    begin
      // reference power follows code and power-down
      // powering up needs a settling wait that software must keep
      int_ref_en_o <= ref_on;
      ref_sel_int_o <= (ref_source_select == `ARCRC_SEL_INT);
      // code 00 routes external pair zero
      ref_sel_ext0_o <= (ref_source_select == `ARCRC_SEL_EXT0);
      // code 01 routes external pair one
      ref_sel_ext1_o <= (ref_source_select == `ARCRC_SEL_EXT1);
      // buffer bits are active low enables
      pos_buf_en_o <= ~pos_ref_buffer_off;
      neg_buf_en_o <= ~neg_ref_buffer_off;
      // clock source follows the select bit
      sys_clk_ext_o <= clk_ext_sel;
      // filter bit 0 low-latency, 1 sinc3
      lowlat_filter_o <= ~filter_sinc3;
      sinc3_filter_o <= filter_sinc3;
      // line notches of the low-latency filter
      notch_50_o <= ~filter_sinc3 & notch_hit(rate_code, 1'b0);
      notch_60_o <= ~filter_sinc3 & notch_hit(rate_code, 1'b1);
      // power-down indication for the analog blocks
      power_down_o <= pdn;
    end
  end

  // modulator clock enable from selected source
  // the divider yields an enable, the modulator logic stays
  // on clk_i, so no second clock domain is created
  arcrc_mod_clk u_mod_clk (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .int_osc_tick_i(int_osc_tick_i),
    .ext_clk_i(ext_clk_i),
    .ext_sel_i(clk_ext_sel),
    .mod_tick_o(mod_tick_o)
  );

  // result timing from rate code only
  // the filter bit is not wired in, both filters share the ratio
  // restart clears the count so a new rate starts clean
  // power-down halts conversions, the modulator clock keeps running
  arcrc_conv u_conv (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .mod_tick_i(mod_tick_o),
    .run_i(run & ~pdn),
    .restart_i(restart),
    .rate_code_i(rate_code),
    .done_o(data_ready_o)
  );

endmodule // arcrc_top
`default_nettype wire

// ### bench/arcrc_props.sv
// concurrent checks on the ports of the reference, clock and rate block
`timescale 1ns/1ps
`default_nettype none
module arcrc_props (
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  input wire wb_ack_o,
  input wire int_ref_en_o,
  input wire ref_sel_int_o,
  input wire ref_sel_ext0_o,
  input wire ref_sel_ext1_o,
  input wire pos_buf_en_o,
  input wire neg_buf_en_o,
  input wire sys_clk_ext_o,
  input wire mod_tick_o,
  input wire lowlat_filter_o,
  input wire sinc3_filter_o,
  input wire notch_50_o,
  input wire notch_60_o,
  input wire data_ready_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // accepted write to reference_control, seen at its ack edge
  wire wr_ref = wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0] && wb_adr_i == 8'h14;
  AST_WB_ACK: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing after request");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  AST_RST_DEF: assert property ($fell(rst_i) |-> !sys_clk_ext_o && ref_sel_ext0_o
    && !int_ref_en_o && sinc3_filter_o) else $error("bad state after reset");
  AST_REF_MUX: assert property ($onehot0({ref_sel_int_o, ref_sel_ext0_o, ref_sel_ext1_o}))
    else $error("reference mux not one-hot");
  AST_SEL_INT: assert property (wr_ref && wb_dat_i[3:2] == 2'h2 |-> ##2 ref_sel_int_o)
    else $error("internal reference not routed");
  AST_BUF_LOW: assert property (wr_ref ##2 1'b1 |-> (pos_buf_en_o == !$past(wb_dat_i[5], 2))
    && (neg_buf_en_o == !$past(wb_dat_i[4], 2))) else $error("buffer enable polarity");
  AST_FILT: assert property (lowlat_filter_o != sinc3_filter_o)
    else $error("filter choice not exclusive");
  AST_NOTCH: assert property (notch_50_o || notch_60_o |-> lowlat_filter_o)
    else $error("notch without low-latency filter");
  AST_MOD_GAP: assert property (mod_tick_o |=> !mod_tick_o [*8])
    else $error("modulator ticks too close");
  AST_DRDY: assert property (data_ready_o |-> $past(mod_tick_o) ##1 !data_ready_o)
    else $error("result pulse not after tick");
  COV_REF: cover property (wr_ref);
  COV_DRDY: cover property (data_ready_o);
  COV_N60: cover property (notch_60_o);
endmodule // arcrc_props
bind arcrc_top arcrc_props u_arcrc_props (.*);
`default_nettype wire

// ### bench/test_arcrc_top.sv
// self-checking bench for the reference, clock and rate block
`timescale 1ns/1ps
`default_nettype none
module test_arcrc_top;
  logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd_q;
  logic int_osc_tick_i = 1'b0, ext_clk_i = 1'b0;
  logic wb_ack_o, int_ref_en_o, ref_sel_int_o, ref_sel_ext0_o, ref_sel_ext1_o, pos_buf_en_o;
  logic neg_buf_en_o, sys_clk_ext_o, mod_tick_o, lowlat_filter_o, sinc3_filter_o;
  logic notch_50_o, notch_60_o, data_ready_o, power_down_o;
  logic [2:0] ext_cnt_q = 3'h0;
  // reference writes and expected {en, int, ext0, ext1, pos_en, neg_en}
  // internal source written with both buffers off
  // one buffer off, as for an input tied to its rail
  logic [7:0] rc_v [5] = '{8'h02, 8'h05, 8'h38, 8'h22, 8'h12};
  logic [5:0] rc_e [5] = '{6'h2B, 6'h27, 6'h10, 6'h29, 6'h2A};
  // low-latency rate codes and expected {notch50, notch60}
  logic [3:0] nc_v [8] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h3, 4'h5, 4'h6, 4'h7};
  logic [1:0] nc_e [8] = '{2'h3, 2'h3, 2'h3, 2'h3, 2'h2, 2'h2, 2'h1, 2'h0};
  int err_total = 0, tests_run = 0;
  arcrc_top u_arcrc_top (.*);
  always #2 clk_i = ~clk_i;
  // oscillator tick every second cycle, slow external clock
  always @(posedge clk_i)
  begin
    int_osc_tick_i <= ~int_osc_tick_i;
    ext_cnt_q <= ext_cnt_q + 3'h1;
    if (ext_cnt_q == 3'h7) ext_clk_i <= ~ext_clk_i;
  end
  task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      $display("ERROR %s expected %h seen %h", name, exp, seen);
      err_total++;
    end
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // one classic wishbone cycle, held until ack is sampled
  task wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int n;
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} <= {2'b11, we, adr, 4'hF, dat};
    for (n = 0; n < 50 && wb_ack_o !== 1'b1; n++) @(posedge clk_i);
    if (n == 50) begin err_total++; complete_run; end
    rd_q = wb_dat_o;
    {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
  endtask
  task settle;
    repeat (3) @(posedge clk_i);
    #1;
  endtask
  task t_reset;
    chk("ref", {int_ref_en_o, ref_sel_int_o, ref_sel_ext0_o, ref_sel_ext1_o}, 4'h2);
    chk("bufs", {pos_buf_en_o, neg_buf_en_o, sys_clk_ext_o, sinc3_filter_o}, 4'h1);
    wb(1'b0, 8'h10, 32'h0); chk("dr reset", rd_q, 32'h14);
    wb(1'b0, 8'h14, 32'h0); chk("rc reset", rd_q, 32'h30);
    wb(1'b1, 8'h40, 32'hFF); wb(1'b0, 8'h40, 32'h0); chk("unmapped", rd_q, 32'h0);
  endtask
  task t_ref;
    int i;
    for (i = 0; i < 5; i++)
    begin
      wb(1'b1, 8'h14, {24'h0, rc_v[i]});
      settle;
      chk("ref out", {int_ref_en_o, ref_sel_int_o, ref_sel_ext0_o, ref_sel_ext1_o,
        pos_buf_en_o, neg_buf_en_o}, rc_e[i]);
    end
    // power-down keeps code 10 on, turns code 01 off
    wb(1'b1, 8'h1C, 32'h1); settle; chk("pd always", int_ref_en_o, 1'b1);
    chk("pd out", power_down_o, 1'b1);
    wb(1'b1, 8'h14, 32'h1); settle; chk("pd auto", int_ref_en_o, 1'b0);
    wb(1'b1, 8'h1C, 32'h0); settle; chk("auto on", int_ref_en_o, 1'b1);
    chk("pd clear", power_down_o, 1'b0);
  endtask
  task t_clk;
    int n, ticks, gap, last;
    ticks = 0;
    gap = 0;
    last = 0;
    wb(1'b1, 8'h10, 32'h54); settle; chk("ext clk", sys_clk_ext_o, 1'b1);
    // external pin toggles every 8 cycles, so 16 of its rising edges span 256
    for (n = 0; n < 1000 && ticks < 2; n++)
    begin
      @(posedge clk_i);
      #1;
      if (mod_tick_o === 1'b1)
      begin
        ticks++;
        gap = n - last;
        last = n;
      end
    end
    if (n == 1000) begin err_total++; complete_run; end
    chk("ext mod gap", gap, 256);
    wb(1'b1, 8'h1C, 32'h4); settle; chk("cmd reset clk", sys_clk_ext_o, 1'b0);
    wb(1'b0, 8'h10, 32'h0); chk("cmd reset dr", rd_q, 32'h14);
    // pin reset in mid-run drops the external clock choice too
    wb(1'b1, 8'h10, 32'h54);
    settle;
    chk("ext again", sys_clk_ext_o, 1'b1);
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    settle;
    chk("pin reset clk", sys_clk_ext_o, 1'b0);
    wb(1'b0, 8'h10, 32'h0);
    chk("pin reset dr", rd_q, 32'h14);
  endtask
  task t_notch;
    int i;
    for (i = 0; i < 8; i++)
    begin
      wb(1'b1, 8'h10, {28'h0, nc_v[i]});
      settle;
      chk("notch", {notch_50_o, notch_60_o, lowlat_filter_o}, {nc_e[i], 1'b1});
    end
    // code 7 left in place: low-latency filter, no notch, ref off
    wb(1'b0, 8'h18, 32'h0);
    chk("status", rd_q, 32'h04);
    wb(1'b1, 8'h10, 32'h10); settle;
    chk("sinc3", {notch_50_o, notch_60_o, sinc3_filter_o}, 3'h1);
  endtask
  // modulator ticks between two results and cycles between ticks
  task t_rate(input logic [3:0] code, input logic filt, input int osr);
    int n, ticks, gap, last;
    ticks = -1; gap = 0; last = 0;
    wb(1'b1, 8'h10, {27'h0, filt, code});
    for (n = 0; n < 20000; n++)
    begin
      @(posedge clk_i); #1;
      if (mod_tick_o === 1'b1) begin gap = n - last; last = n; if (ticks >= 0) ticks++; end
      if (data_ready_o === 1'b1) begin if (ticks >= 0) break; ticks = 0; end
    end
    if (n == 20000) begin err_total++; complete_run; end
    chk("osr", ticks, osr);
    chk("mod gap", gap, 32);
  endtask
  initial
  begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset;
    t_ref;
    t_clk;
    t_notch;
    // internal reference is off here and no excitation
    // source is in use, so conversions may start without a wait
    wb(1'b1, 8'h1C, 32'h2);
    t_rate(4'hD, 1'b0, 64);
    t_rate(4'hD, 1'b1, 64);
    t_rate(4'hC, 1'b1, 128);
    complete_run;
  end
endmodule // test_arcrc_top
`default_nettype wire
